// ---- rtl/core_pkg.sv ----
// Shared constants and carrier types of the core register model
package core_pkg;
  localparam int INSN_W = 24;
  localparam int PC_W = 23;
  localparam int W_COUNT = 16;
  localparam int NUM_TRAPS = 8;
  localparam int NUM_IRQS = 54;
  localparam int NUM_VECTORS = 62;
  localparam int IRQ_PRIO_W = 3;
  localparam int PRIO_W = 4;
  localparam logic [3:0] TRAP_PRIO_BASE = 4'h8;
  localparam logic [7:0] TRAP_VALID_MASK = 8'h1e;
  localparam logic [22:0] VECTOR_BASE = 23'h000004;
  localparam logic [3:0] SP_IDX = 4'hf;
  localparam logic [3:0] FP_IDX = 4'he;
  localparam logic [3:0] DEF_IDX = 4'h0;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam int ST_C = 0;
  localparam int ST_Z = 1;
  localparam int ST_OV = 2;
  localparam int ST_N = 3;
  localparam int ST_RA = 4;
  localparam int ST_IPL = 5;
  localparam int ST_DC = 8;
  localparam int ST_DA = 9;
  localparam logic [15:0] SHADOW_SR_MASK = 16'h010f;
  localparam logic [15:0] WREG_END = 16'h0020;
  localparam logic [15:0] OFS_TABLE_PAGE_REG = 16'h0032;
  localparam logic [15:0] OFS_PROGRAM_WINDOW_PAGE = 16'h0034;
  localparam logic [15:0] OFS_REPEAT_ITERATION_COUNT = 16'h0036;
  localparam logic [15:0] OFS_LOOP_CNT = 16'h0038;
  localparam logic [15:0] OFS_LOOP_START = 16'h003a;
  localparam logic [15:0] OFS_LOOP_END = 16'h003e;
  localparam logic [15:0] OFS_SR = 16'h0042;
  localparam logic [15:0] Y_SPACE_BASE = 16'h0c00;
  localparam logic [15:0] Y_SPACE_END = 16'h1000;
  localparam int PSV_WINDOW_BIT = 15;
  localparam int SHIFT_MAX_RIGHT = 15;
  localparam int SHIFT_MAX_LEFT = 16;
  localparam int ACC_W = 40;

  typedef struct packed {
    logic push_shadow;
    logic pop_shadow;
    logic call;
    logic ret;
    logic frame_link;
    logic frame_unlink;
    logic loop_begin;
    logic loop_end;
    logic repeat_begin;
    logic repeat_step;
  } core_event_t;

  typedef struct packed {
    logic [22:0] start;
    logic [22:0] stop;
    logic [15:0] count;
  } loop_regs_t;
endpackage

// ---- rtl/exc_arbiter.sv ----
// Exception priority resolver for traps and interrupts
`timescale 1ns/1ps
module exc_arbiter #(
  parameter int NUM_IRQS = 54,
  parameter int NUM_TRAPS = 8
) (
  input wire logic [NUM_IRQS-1:0] irq_pend,
  input wire logic [NUM_IRQS*3-1:0] irq_prio,
  input wire logic [NUM_TRAPS-1:0] trap_pend,
  input wire logic [2:0] cpu_ipl,
  output logic req,
  output logic [5:0] vec_idx,
  output logic [3:0] prio
);
  generate
    if (NUM_IRQS + NUM_TRAPS != core_pkg::NUM_VECTORS) begin
      $error("vector count mismatch");
    end
  endgenerate

  logic [NUM_TRAPS-1:0] trap_live;
  assign trap_live = trap_pend & core_pkg::TRAP_VALID_MASK;

  always_comb begin
    prio = 4'h0;
    vec_idx = 6'h00;
    // Higher index first so lower index wins ties
    for (int i = NUM_IRQS - 1; i >= 0; i--) begin
      if (irq_pend[i] && irq_prio[i*3 +: 3] != 3'h0 &&
          {1'b0, irq_prio[i*3 +: 3]} >= prio) begin
        prio = {1'b0, irq_prio[i*3 +: 3]};
        vec_idx = 6'(NUM_TRAPS + i);
      end
    end
    for (int t = 0; t < NUM_TRAPS; t++) begin
      if (trap_live[NUM_TRAPS-1-t]) begin
        prio = core_pkg::TRAP_PRIO_BASE + 4'(NUM_TRAPS-1-t);
        vec_idx = 6'(NUM_TRAPS-1-t);
      end
    end
    req = prio > {1'b0, cpu_ipl};
  end
endmodule

// ---- rtl/barrel_shift.sv ----
// Single-cycle shifter, right up to 15 or left up to 16
`timescale 1ns/1ps
module barrel_shift #(
  parameter int WIDTH = 40
) (
  input wire logic [WIDTH-1:0] src,
  input wire logic signed [5:0] amt,
  output logic [WIDTH-1:0] res
);
  generate
    if (WIDTH <= core_pkg::SHIFT_MAX_LEFT) begin
      $error("shifter too narrow");
    end
  endgenerate

  logic [5:0] mag;
  assign mag = amt[5] ? 6'(-amt) : 6'(amt);

  always_comb begin
    if (amt[5]) begin
      res = (mag > 6'(core_pkg::SHIFT_MAX_LEFT)) ? src :
            src << mag;
    end else begin
      res = (mag > 6'(core_pkg::SHIFT_MAX_RIGHT)) ? src :
            WIDTH'($signed(src) >>> mag);
    end
  end
endmodule

// ---- rtl/core_regs.sv ----
// Programmer-visible register model of the signal controller core
`timescale 1ns/1ps
module core_regs #(
  parameter int NUM_IRQS = 54,
  parameter int NUM_TRAPS = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [23:0] fetch_word,
  input wire logic fetch_valid,
  input wire logic special_op,
  input wire logic branch_en,
  input wire logic [22:0] branch_pc,
  input wire logic [23:0] prog_rdata,
  input wire logic wb_en,
  input wire logic wb_byte,
  input wire logic wb_file_reg,
  input wire logic [3:0] wb_idx,
  input wire logic [15:0] wb_data,
  input wire logic flags_en,
  input wire logic [15:0] flags_mask,
  input wire logic [15:0] flags_in,
  input wire logic [3:0] rd_idx,
  input wire logic ds_req,
  input wire logic ds_wr,
  input wire logic [1:0] ds_be,
  input wire logic [15:0] ds_addr,
  input wire logic [15:0] ds_wdata,
  input wire logic psv_enable,
  input wire logic tbl_rd,
  input wire logic [15:0] tbl_offset,
  input wire core_pkg::core_event_t ev,
  input wire logic [22:0] ret_pc,
  input wire logic [15:0] link_size,
  input wire logic [15:0] stack_rdata,
  input wire core_pkg::loop_regs_t loop_in,
  input wire logic [15:0] repeat_in,
  input wire logic [NUM_IRQS-1:0] irq_pend,
  input wire logic [NUM_IRQS*3-1:0] irq_prio,
  input wire logic [NUM_TRAPS-1:0] trap_pend,
  input wire logic shift_src_acc,
  input wire logic [39:0] acc_in,
  input wire logic [3:0] shift_widx,
  input wire logic signed [5:0] shift_amt,
  output logic [22:0] prog_addr_q,
  output logic [23:0] exec_insn_q,
  output logic [15:0] rd_data_q,
  output logic [15:0] ds_rdata_q,
  output logic ds_ready_q,
  output logic ds_y_q,
  output logic [23:0] tbl_data_q,
  output logic stack_wr_q,
  output logic [15:0] stack_addr_q,
  output logic [15:0] stack_data_q,
  output logic [15:0] status_q,
  output logic [15:0] sp_q,
  output logic exc_ack_q,
  output logic [5:0] exc_vec_q,
  output logic [39:0] shift_q
);
  typedef enum logic [1:0] {ST_RUN, ST_PUSH_LO, ST_PUSH_HI, ST_PROG_RD}
    seq_t;

  ////////////////////////////////////////////////////////////////////////
  // State
  seq_t seq_q;
  logic seq_exc_q;
  logic seq_tbl_q;
  logic [5:0] vec_q;
  logic [3:0] vprio_q;
  logic [22:0] pc_q;
  logic [22:0] tgt_q;
  logic [23:0] pref_q;
  logic [15:0] w_q [core_pkg::W_COUNT];
  logic [15:0] sh_w_q [4];
  logic [15:0] sh_sr_q;
  logic [15:0] sr_q;
  logic [7:0] program_window_page_q;
  logic [7:0] table_page_reg_q;
  logic [15:0] repeat_iteration_count_q;
  core_pkg::loop_regs_t loop_q;
  core_pkg::loop_regs_t loop_sh_q;
  logic loop_sh_full_q;

  ////////////////////////////////////////////////////////////////////////
  // Exception resolve and shifter
  logic exc_req;
  logic [5:0] exc_idx;
  logic [3:0] exc_prio;
  logic [39:0] shift_res;
  logic [39:0] shift_src;

  exc_arbiter #(.NUM_IRQS(NUM_IRQS), .NUM_TRAPS(NUM_TRAPS)) u_arb (
    .irq_pend(irq_pend),
    .irq_prio(irq_prio),
    .trap_pend(trap_pend),
    .cpu_ipl(sr_q[core_pkg::ST_IPL +: 3]),
    .req(exc_req),
    .vec_idx(exc_idx),
    .prio(exc_prio)
  );

  assign shift_src = shift_src_acc ? acc_in :
                     {{24{w_q[shift_widx][15]}}, w_q[shift_widx]};

  barrel_shift #(.WIDTH(core_pkg::ACC_W)) u_shift (
    .src(shift_src),
    .amt(shift_amt),
    .res(shift_res)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode
  logic running;
  logic exc_take;
  logic call_take;
  logic ds_w_hit;
  logic [3:0] ds_widx;
  logic ds_psv;
  logic ds_wr_go;
  logic [15:0] ds_mask;
  logic [3:0] wb_tgt;
  logic [15:0] wb_mask;
  logic [22:0] pc_next_seq;
  logic [22:0] vec_addr;
  logic [22:0] psv_addr;
  logic [22:0] tbl_addr;
  logic [15:0] sp_cur;
  logic [15:0] map_rdata;

  assign running = seq_q == ST_RUN;
  // Loop and repeat state never blocks an exception
  assign exc_take = running && exc_req;
  assign call_take = running && !exc_req && ev.call;
  assign ds_w_hit = ds_addr < core_pkg::WREG_END;
  assign ds_widx = ds_addr[4:1];
  assign ds_psv = psv_enable && ds_addr[core_pkg::PSV_WINDOW_BIT];
  assign ds_wr_go = running && ds_req && ds_wr && !ds_psv;
  assign ds_mask = {{8{ds_be[1]}}, {8{ds_be[0]}}};
  assign wb_tgt = wb_file_reg ? core_pkg::DEF_IDX : wb_idx;
  assign wb_mask = wb_byte ? 16'h00ff : 16'hffff;
  assign pc_next_seq = pc_q + 23'h2;
  assign vec_addr = core_pkg::VECTOR_BASE + {16'h0, exc_idx, 1'b0};
  assign psv_addr = {program_window_page_q, ds_addr[14:1], 1'b0};
  assign tbl_addr = {table_page_reg_q[6:0], tbl_offset[15:1], 1'b0};
  assign sp_cur = w_q[core_pkg::SP_IDX];

  // Shadows are absent from this map
  always_comb begin
    map_rdata = 16'h0000;
    if (ds_w_hit) begin
      map_rdata = w_q[ds_widx];
    end else begin
      case (ds_addr & 16'hfffe)
        core_pkg::OFS_SR: map_rdata = sr_q;
        core_pkg::OFS_PROGRAM_WINDOW_PAGE: map_rdata = {8'h00, program_window_page_q};
        core_pkg::OFS_TABLE_PAGE_REG: map_rdata = {8'h00, table_page_reg_q};
        core_pkg::OFS_REPEAT_ITERATION_COUNT: map_rdata = repeat_iteration_count_q;
        core_pkg::OFS_LOOP_CNT: map_rdata = loop_q.count;
        core_pkg::OFS_LOOP_START: map_rdata = loop_q.start[15:0];
        core_pkg::OFS_LOOP_END: map_rdata = loop_q.stop[15:0];
        default: map_rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stack pointer next value
  logic sp_auto;
  logic [15:0] sp_auto_val;
  logic fp_auto;
  logic [15:0] fp_auto_val;

  always_comb begin
    sp_auto = 1'b1;
    sp_auto_val = sp_cur;
    fp_auto = 1'b0;
    fp_auto_val = w_q[core_pkg::FP_IDX];
    if (seq_q == ST_PUSH_LO || seq_q == ST_PUSH_HI) begin
      sp_auto_val = sp_cur + core_pkg::STACK_STEP;
    end else if (running && !exc_req && ev.ret) begin
      sp_auto_val = sp_cur - core_pkg::STACK_STEP - core_pkg::STACK_STEP;
    end else if (running && !exc_req && ev.frame_link) begin
      fp_auto = 1'b1;
      fp_auto_val = sp_cur + core_pkg::STACK_STEP;
      sp_auto_val = sp_cur + core_pkg::STACK_STEP + link_size;
    end else if (running && !exc_req && ev.frame_unlink) begin
      fp_auto = 1'b1;
      fp_auto_val = stack_rdata;
      sp_auto_val = w_q[core_pkg::FP_IDX] - core_pkg::STACK_STEP;
    end else begin
      sp_auto = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Working registers, one slice per entry
  genvar gi;
  generate
    for (gi = 0; gi < core_pkg::W_COUNT; gi++) begin : g_w
      logic [15:0] w_d;
      always_comb begin
        w_d = w_q[gi];
        if (ds_wr_go && ds_w_hit && ds_widx == 4'(gi)) begin
          w_d = (w_q[gi] & ~ds_mask) | (ds_wdata & ds_mask);
        end else if (wb_en && running && wb_tgt == 4'(gi)) begin
          w_d = (w_q[gi] & ~wb_mask) | (wb_data & wb_mask);
        end
        if (gi < 4 && running && ev.pop_shadow) begin
          w_d = sh_w_q[gi % 4];
        end
        if (gi == core_pkg::FP_IDX && fp_auto) begin
          w_d = fp_auto_val;
        end
        if (gi == core_pkg::SP_IDX && sp_auto) begin
          w_d = sp_auto_val;
        end
        if (gi == core_pkg::SP_IDX) begin
          w_d[0] = 1'b0;
        end
      end
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          w_q[gi] <= (gi == core_pkg::SP_IDX) ? core_pkg::SP_RESET :
                     16'h0000;
        end else begin
          w_q[gi] <= w_d;
        end
      end
      if (gi < 4) begin : g_sh
        always_ff @(posedge mclk) begin
          if (!nrst) begin
            sh_w_q[gi] <= 16'h0000;
          end else if (running && ev.push_shadow) begin
            sh_w_q[gi] <= w_q[gi];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Status word
  logic [15:0] sr_d;
  always_comb begin
    sr_d = sr_q;
    if (flags_en) begin
      sr_d = (sr_q & ~flags_mask) | (flags_in & flags_mask);
    end
    if (ds_wr_go && (ds_addr & 16'hfffe) == core_pkg::OFS_SR) begin
      sr_d = (sr_q & ~ds_mask) | (ds_wdata & ds_mask);
    end
    if (running && ev.pop_shadow) begin
      sr_d = (sr_q & ~core_pkg::SHADOW_SR_MASK) |
             (sh_sr_q & core_pkg::SHADOW_SR_MASK);
    end
    if (running && ev.repeat_begin) begin
      sr_d[core_pkg::ST_RA] = 1'b1;
    end else if (running && ev.repeat_step && repeat_iteration_count_q == 16'h0000) begin
      sr_d[core_pkg::ST_RA] = 1'b0;
    end
    if (running && ev.loop_begin) begin
      sr_d[core_pkg::ST_DA] = 1'b1;
    end else if (running && ev.loop_end) begin
      sr_d[core_pkg::ST_DA] = loop_sh_full_q;
    end
    if (seq_q == ST_PUSH_HI && seq_exc_q) begin
      sr_d[core_pkg::ST_IPL +: 3] = vprio_q[3] ? 3'h7 : vprio_q[2:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sr_q <= core_pkg::STATUS_RESET;
      sh_sr_q <= core_pkg::STATUS_RESET;
    end else begin
      sr_q <= sr_d;
      if (running && ev.push_shadow) begin
        sh_sr_q <= sr_q & core_pkg::SHADOW_SR_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pages, repeat count and loop registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      program_window_page_q <= core_pkg::PAGE_RESET;
      table_page_reg_q <= core_pkg::PAGE_RESET;
      repeat_iteration_count_q <= 16'h0000;
      loop_q <= '0;
      loop_sh_q <= '0;
      loop_sh_full_q <= 1'b0;
    end else begin
      if (ds_wr_go && (ds_addr & 16'hfffe) == core_pkg::OFS_PROGRAM_WINDOW_PAGE) begin
        program_window_page_q <= ds_wdata[7:0];
      end
      if (ds_wr_go && (ds_addr & 16'hfffe) == core_pkg::OFS_TABLE_PAGE_REG) begin
        table_page_reg_q <= ds_wdata[7:0];
      end
      if (running && ev.repeat_begin) begin
        repeat_iteration_count_q <= repeat_in;
      end else if (running && ev.repeat_step && repeat_iteration_count_q != 16'h0000) begin
        repeat_iteration_count_q <= repeat_iteration_count_q - 16'h0001;
      end
      if (running && ev.loop_begin) begin
        loop_sh_q <= loop_q;
        loop_sh_full_q <= sr_q[core_pkg::ST_DA];
        loop_q <= loop_in;
      end else if (running && ev.loop_end) begin
        loop_q <= loop_sh_q;
        loop_sh_full_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: prefetch, stacking, program-space reads
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      seq_q <= ST_RUN;
      seq_exc_q <= 1'b0;
      seq_tbl_q <= 1'b0;
      vec_q <= 6'h00;
      vprio_q <= 4'h0;
      pc_q <= 23'h000000;
      tgt_q <= 23'h000000;
      pref_q <= 24'h000000;
      exec_insn_q <= 24'h000000;
      prog_addr_q <= 23'h000000;
    end else begin
      case (seq_q)
        ST_RUN: begin
          if (exc_take || call_take) begin
            seq_q <= ST_PUSH_LO;
            seq_exc_q <= exc_take;
            vec_q <= exc_idx;
            vprio_q <= exc_prio;
            // Counter kept until stacked, target loaded afterwards
            tgt_q <= exc_take ? vec_addr : {branch_pc[22:1], 1'b0};
          end else if (ds_req && !ds_wr && ds_psv) begin
            seq_q <= ST_PROG_RD;
            seq_tbl_q <= 1'b0;
            prog_addr_q <= psv_addr;
          end else if (tbl_rd) begin
            seq_q <= ST_PROG_RD;
            seq_tbl_q <= 1'b1;
            prog_addr_q <= tbl_addr;
          end else if (ev.ret) begin
            pc_q <= {ret_pc[22:1], 1'b0};
          end else if (branch_en) begin
            pc_q <= {branch_pc[22:1], 1'b0};
          end else if (fetch_valid) begin
            pref_q <= fetch_word;
            exec_insn_q <= pref_q;
            pc_q <= pc_next_seq;
          end
          if (!(exc_take || call_take) && !(ds_req && !ds_wr && ds_psv) &&
              !tbl_rd) begin
            prog_addr_q <= special_op ? pc_q :
                           {1'b0, pc_q[21:1], 1'b0};
          end
        end
        ST_PUSH_LO: seq_q <= ST_PUSH_HI;
        ST_PUSH_HI: begin
          seq_q <= ST_RUN;
          pc_q <= tgt_q;
        end
        ST_PROG_RD: seq_q <= ST_RUN;
        default: seq_q <= ST_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stack writes, data port answers, outputs
  logic [22:0] ret_addr;
  assign ret_addr = seq_exc_q ? pc_q : pc_next_seq;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stack_wr_q <= 1'b0;
      stack_addr_q <= 16'h0000;
      stack_data_q <= 16'h0000;
      exc_ack_q <= 1'b0;
      exc_vec_q <= 6'h00;
      ds_rdata_q <= 16'h0000;
      ds_ready_q <= 1'b0;
      ds_y_q <= 1'b0;
      tbl_data_q <= 24'h000000;
      rd_data_q <= 16'h0000;
      status_q <= core_pkg::STATUS_RESET;
      sp_q <= core_pkg::SP_RESET;
      shift_q <= 40'h0000000000;
    end else begin
      stack_wr_q <= seq_q == ST_PUSH_LO || seq_q == ST_PUSH_HI;
      stack_addr_q <= sp_cur;
      if (seq_q == ST_PUSH_HI) begin
        stack_data_q <= {seq_exc_q ? sr_q[7:0] : 8'h00, 1'b0,
                         ret_addr[22:16]};
      end else begin
        stack_data_q <= ret_addr[15:0];
      end
      exc_ack_q <= seq_q == ST_PUSH_HI && seq_exc_q;
      exc_vec_q <= vec_q;
      ds_ready_q <= (running && ds_req && !ds_psv && !exc_req) ||
                    (seq_q == ST_PROG_RD && !seq_tbl_q);
      if (seq_q == ST_PROG_RD && !seq_tbl_q) begin
        ds_rdata_q <= prog_rdata[15:0];
      end else if (running && ds_req && !ds_wr) begin
        ds_rdata_q <= map_rdata;
      end
      ds_y_q <= ds_addr >= core_pkg::Y_SPACE_BASE &&
                ds_addr < core_pkg::Y_SPACE_END;
      if (seq_q == ST_PROG_RD && seq_tbl_q) begin
        tbl_data_q <= prog_rdata;
      end
      rd_data_q <= w_q[rd_idx];
      status_q <= sr_q;
      sp_q <= sp_cur;
      shift_q <= shift_res;
    end
  end
endmodule

// ---- tb/core_regs_properties.sv ----
// Port assertions for the core register model
`timescale 1ns/1ps
module core_regs_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ds_req,
  input wire logic ds_wr,
  input wire logic [15:0] ds_addr,
  input wire logic psv_enable,
  input wire logic shift_src_acc,
  input wire logic [39:0] acc_in,
  input wire logic signed [5:0] shift_amt,
  input wire logic [22:0] prog_addr_q,
  input wire logic stack_wr_q,
  input wire logic [15:0] stack_addr_q,
  input wire logic [15:0] status_q,
  input wire logic [15:0] sp_q,
  input wire logic exc_ack_q,
  input wire logic [5:0] exc_vec_q,
  input wire logic [39:0] shift_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire psv_rd = ds_req && !ds_wr && psv_enable && ds_addr[15];
  ////////////////////////////////////////////////////////////////////////
  AST_SP_ALIGN: assert property (sp_q[0] == 1'b0)
    else $error("stack pointer odd");
  AST_SP_RESET: assert property ($rose(nrst) |-> sp_q == 16'h0800)
    else $error("stack pointer reset value");
  AST_PC_ALIGN: assert property (prog_addr_q[0] == 1'b0)
    else $error("program address odd");
  AST_EXC_STACK: assert property (exc_ack_q |->
    stack_wr_q && $past(stack_wr_q))
    else $error("ack without two stack writes");
  AST_VEC_RANGE: assert property (exc_ack_q |->
    exc_vec_q inside {[6'h01:6'h04], [6'h08:6'h3d]})
    else $error("vector out of range");
  AST_TRAP_IPL: assert property (exc_ack_q && exc_vec_q < 6'h08 |=>
    status_q[7:5] == 3'h7)
    else $error("trap priority level");
  AST_STACK_STEP: assert property (stack_wr_q && $past(stack_wr_q) |->
    stack_addr_q == $past(stack_addr_q) + 16'h0002)
    else $error("stack step");
  AST_PSV_ADDR: assert property (psv_rd |=>
    prog_addr_q[14:0] == {$past(ds_addr[14:1]), 1'b0})
    else $error("window address");
  AST_SHIFT_LEFT: assert property (shift_src_acc && shift_amt == -6'sd16
    |=> shift_q == {$past(acc_in[23:0]), 16'h0000})
    else $error("left shift");
  ////////////////////////////////////////////////////////////////////////
  cover property (exc_ack_q);
  cover property (psv_rd);
  cover property (stack_wr_q [*2]);
endmodule
bind core_regs core_regs_checker props (.mclk, .nrst, .ds_req, .ds_wr,
  .ds_addr, .psv_enable, .shift_src_acc, .acc_in, .shift_amt, .prog_addr_q,
  .stack_wr_q, .stack_addr_q, .status_q, .sp_q, .exc_ack_q, .exc_vec_q,
  .shift_q);

// ---- tb/tb_top.sv ----
// Self-checking bench for the core register model
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic fetch_valid, special_op, branch_en, wb_en, wb_byte, wb_file_reg;
  logic flags_en, ds_req, ds_wr, psv_enable, tbl_rd, shift_src_acc;
  logic [1:0] ds_be;
  logic [3:0] wb_idx, rd_idx, shift_widx;
  logic signed [5:0] shift_amt;
  logic [7:0] trap_pend;
  logic [15:0] wb_data, flags_mask, flags_in, ds_addr, ds_wdata, tbl_offset;
  logic [15:0] link_size, stack_rdata, repeat_in, rv, a0, d0, d1;
  logic [22:0] branch_pc, ret_pc, prog_addr_q;
  logic [23:0] fetch_word, prog_rdata, exec_insn_q, tbl_data_q;
  logic [39:0] acc_in, shift_q;
  logic [53:0] irq_pend;
  logic [161:0] irq_prio;
  core_pkg::core_event_t ev;
  core_pkg::loop_regs_t loop_in;
  logic [15:0] rd_data_q, ds_rdata_q, stack_addr_q, stack_data_q;
  logic [15:0] status_q, sp_q;
  logic ds_ready_q, ds_y_q, stack_wr_q, exc_ack_q;
  logic [5:0] exc_vec_q;
  logic [53:0] pend_t [3] = '{54'h40c, 54'h404, 54'h004};
  logic [2:0] ipl_t [3] = '{3'h0, 3'h4, 3'h2};
  logic [2:0] prio_t [3] = '{3'h5, 3'h5, 3'h3};
  logic [5:0] vec_t [3] = '{6'h0b, 6'h12, 6'h0a};
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  core_regs DUT (.*);
  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic at(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] i, input logic [15:0] d,
                      input logic b, input logic f);
    @(posedge mclk);
    wb_en <= 1'b1;
    wb_idx <= i;
    wb_data <= d;
    wb_byte <= b;
    wb_file_reg <= f;
    @(posedge mclk);
    wb_en <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] i);
    @(posedge mclk);
    rd_idx <= i;
    at(1);
    rv = rd_data_q;
  endtask
  task automatic dsop(input logic w, input logic [1:0] be,
                      input logic [15:0] a, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    ds_req <= 1'b1;
    ds_wr <= w;
    ds_be <= be;
    ds_addr <= a;
    ds_wdata <= wd;
    @(posedge mclk);
    ds_req <= 1'b0;
    #1;
    while (ds_ready_q !== 1'b1 && n < 6) begin
      at(1);
      n++;
    end
    chk(ds_ready_q, 1'b1);
    rv = ds_rdata_q;
  endtask
  task automatic flags(input logic [15:0] m, input logic [15:0] v);
    @(posedge mclk);
    flags_en <= 1'b1;
    flags_mask <= m;
    flags_in <= v;
    @(posedge mclk);
    flags_en <= 1'b0;
  endtask
  task automatic pulse(input logic [9:0] e);
    @(posedge mclk);
    ev <= core_pkg::core_event_t'(e);
    @(posedge mclk);
    ev <= '0;
  endtask
  task automatic pushes;
    int n;
    n = 0;
    #1;
    while (stack_wr_q !== 1'b1 && n < 8) begin
      at(1);
      n++;
    end
    a0 = stack_addr_q;
    d0 = stack_data_q;
    at(1);
    d1 = stack_data_q;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {fetch_valid, special_op, branch_en, wb_en, wb_byte, wb_file_reg} = '0;
    {flags_en, ds_req, ds_wr, psv_enable, tbl_rd, shift_src_acc} = '0;
    {ds_be, wb_idx, rd_idx, shift_widx, shift_amt, trap_pend} = '0;
    {wb_data, flags_mask, flags_in, ds_addr, ds_wdata, tbl_offset} = '0;
    {link_size, stack_rdata, repeat_in, branch_pc, ret_pc} = '0;
    {fetch_word, prog_rdata, acc_in, irq_pend, irq_prio, ev, loop_in} = '0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    at(1);
    chk(sp_q, 16'h0800);
    chk(status_q, core_pkg::STATUS_RESET);
    for (int i = 0; i < 15; i++) begin
      wreg(4'(i), 16'h1100 + 16'(i), 1'b0, 1'b0);
    end
    for (int i = 0; i < 15; i++) begin
      rreg(4'(i));
      chk(rv, 16'h1100 + 16'(i));
    end
    wreg(4'hf, 16'h1235, 1'b0, 1'b0);
    at(1);
    chk(sp_q, 16'h1234);
    wreg(4'h2, 16'h55ab, 1'b1, 1'b0);
    rreg(4'h2);
    chk(rv, 16'h11ab);
    wreg(4'h9, 16'h0077, 1'b0, 1'b1);
    rreg(4'h0);
    chk(rv, 16'h0077);
    dsop(1'b1, 2'b10, 16'h0006, 16'hee44);
    dsop(1'b0, 2'b11, 16'h0006, 16'h0000);
    chk(rv, 16'hee03);
    chk(ds_y_q, 1'b0);
    dsop(1'b0, 2'b11, 16'h0c00, 16'h0000);
    chk(ds_y_q, 1'b1);
    wreg(4'hf, 16'h0800, 1'b0, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wreg(4'(i), 16'h00a0 + 16'(i), 1'b0, 1'b0);
    end
    flags(16'h011f, 16'h011f);
    pulse(10'h200);
    for (int i = 0; i < 4; i++) begin
      wreg(4'(i), 16'h0000, 1'b0, 1'b0);
    end
    flags(16'h011f, 16'h0000);
    pulse(10'h100);
    at(1);
    chk(status_q & 16'h011f, 16'h010f);
    for (int i = 0; i < 4; i++) begin
      rreg(4'(i));
      chk(rv, 16'h00a0 + 16'(i));
    end
    @(posedge mclk);
    loop_in <= '{23'h000100, 23'h000200, 16'h0005};
    pulse(10'h008);
    dsop(1'b0, 2'b11, core_pkg::OFS_LOOP_CNT, 16'h0000);
    chk(rv, 16'h0005);
    chk(status_q[core_pkg::ST_DA], 1'b1);
    pulse(10'h004);
    dsop(1'b0, 2'b11, core_pkg::OFS_LOOP_CNT, 16'h0000);
    chk(rv, 16'h0000);
    $display("test shadows done");
    @(posedge mclk);
    branch_en <= 1'b1;
    branch_pc <= 23'h120040;
    @(posedge mclk);
    branch_en <= 1'b0;
    trap_pend <= 8'h02;
    irq_pend <= 54'h1;
    irq_prio <= 162'h7;
    @(posedge mclk);
    trap_pend <= 8'h00;
    pushes;
    chk(a0, 16'h0800);
    chk(d0, 16'h0040);
    chk(d1, 16'h0f12);
    chk(exc_ack_q, 1'b1);
    chk(exc_vec_q, 6'h01);
    at(1);
    chk(status_q[7:5], 3'h7);
    chk(sp_q, 16'h0804);
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      irq_pend <= pend_t[k];
      irq_prio <= (162'h3 << 6) | (162'h5 << 9) | (162'h5 << 30);
      flags(16'h00e0, {8'h00, ipl_t[k], 5'h00});
      pushes;
      at(1);
      chk(exc_vec_q, vec_t[k]);
      chk(status_q[7:5], prio_t[k]);
    end
    $display("test exceptions done");
    @(posedge mclk);
    ret_pc <= 23'h400010;
    pulse(10'h080);
    pushes;
    chk(a0, 16'h0810);
    at(2);
    chk(sp_q, 16'h0814);
    pulse(10'h040);
    at(2);
    chk(sp_q, 16'h0810);
    chk(prog_addr_q, 23'h000010);
    link_size <= 16'h0006;
    pulse(10'h020);
    rreg(4'he);
    chk(rv, 16'h0812);
    chk(sp_q, 16'h0818);
    stack_rdata <= 16'h0900;
    pulse(10'h010);
    rreg(4'he);
    chk(rv, 16'h0900);
    chk(sp_q, 16'h0810);
    @(posedge mclk);
    special_op <= 1'b1;
    at(2);
    chk(prog_addr_q, 23'h400010);
    dsop(1'b1, 2'b11, core_pkg::OFS_PROGRAM_WINDOW_PAGE, 16'h0005);
    @(posedge mclk);
    psv_enable <= 1'b1;
    prog_rdata <= 24'habcdef;
    dsop(1'b0, 2'b11, 16'h8010, 16'h0000);
    chk(rv, 16'hcdef);
    @(posedge mclk);
    tbl_rd <= 1'b1;
    tbl_offset <= 16'h0010;
    @(posedge mclk);
    tbl_rd <= 1'b0;
    at(3);
    chk(tbl_data_q, 24'habcdef);
    $display("test program space done");
    @(posedge mclk);
    shift_src_acc <= 1'b1;
    acc_in <= 40'h0012345678;
    shift_amt <= -6'sd16;
    at(2);
    chk(shift_q, 40'h3456780000);
    @(posedge mclk);
    acc_in <= 40'h0080000000;
    shift_amt <= 6'sd15;
    fetch_word <= 24'h123456;
    fetch_valid <= 1'b1;
    at(3);
    chk(shift_q, 40'h0000010000);
    chk(exec_insn_q, 24'h123456);
    $display("test shifter done");
    wrap_up();
  end
endmodule
